/* hdl/usim_top.sv */
// smart-card capable uart channel with an axi4-lite register slave
//
// What this block does
// - data logic select inverts transmit buffer writes and receive buffer reads
// - polarity reversal inverts serial data in and out; the error low and the far error sample are not reversed
// - polarity reversal resets cleared, lines not reversed
// - at each bit sample compare driven pin with input, flag collision
// - channel runs 8-bit asynchronous frames only with mode field 101
// - stop length bit cleared gives one stop bit
// - direct format: even parity, plain data, lsb first
// - inverse format: odd parity, inverted data, msb first
// - bit rate is internal or external source over 16(m+1)
// - flow control handshake disabled by its disable bit
// - transmit request cause may be transmission completed
// - open-drain select makes the serial output open drain
// - transmit starts only when enabled and buffer holds data
// - receive starts only when enabled and start bit seen
// - receive request once character moved into receive buffer
// - overrun, framing, parity errors and error sum are kept
// - receiver drives output low on parity error when enabled
// - transmitter samples input at transmit completion for far error
// - divisor m is eight bits, 00 to FF
// - with error output on and completion as the cause, transmit request means error signal seen
// - inverse sends bit 7 first inverted, direct bit 0 first
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`include "usim_params.svh"
module usim_top
  import usim_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        SERIAL_IN_PIN_IN,
  input  wire logic        SERIAL_CLOCK_PIN_IN,
  input  wire logic        CTS_N_IN,
  output logic             SERIAL_OUT_PIN_OUT,
  output logic             SERIAL_OUT_PIN_OE_OUT
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  usim_byte_t  mode_reg, ctrl0_reg, ctrl1_reg, brg_m, tx_buf, rx_buf;
  logic        aw_hold, w_hold, w_strb0;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_go, wr_en, wr_hit, rd_go, rd_hit;
  logic [31:0] rd_word;
  logic        tx_full, tx_busy, tx_load, tx_done;
  logic [11:0] tx_shift, frame;
  logic [3:0]  tx_sub, tx_left, nbits;
  usim_byte_t  tx_data;
  logic        tx_par;
  usim_rx_e    rx_state;
  logic [3:0]  rx_sub, rx_cnt;
  logic [8:0]  rx_sh;
  usim_byte_t  rx_raw;
  logic        rx_pbit, rx_done, pbad, rx_in;
  logic        rx_full, ovr_err, frm_err, par_err;
  logic [4:0]  err_cnt;
  logic        pin_q, tick16, err_drv;
  logic [3:0]  flags, ev_vec, clr_vec;
  logic        chan_on, rev, pen, peven, stop2, msbf, odrain, flowdis;
  logic        txen, rxen, txcause, dlogic, err_out, bc_ev, tx_ev;

  // only the 8-bit asynchronous mode runs the channel
  assign chan_on = (mode_reg[2:0] == `USIM_MODE_UART8);
  assign rev     = mode_reg[`USIM_MODE_REV];
  assign pen     = mode_reg[`USIM_MODE_PEN];
  assign peven   = mode_reg[`USIM_MODE_PEVEN];
  assign stop2   = mode_reg[`USIM_MODE_STOP2];
  assign msbf    = ctrl0_reg[`USIM_C0_MSBF];
  assign odrain  = ctrl0_reg[`USIM_C0_ODRAIN];
  assign flowdis = ctrl0_reg[`USIM_C0_FLOWDIS];
  assign txen    = ctrl1_reg[`USIM_C1_TXEN];
  assign rxen    = ctrl1_reg[`USIM_C1_RXEN];
  assign txcause = ctrl1_reg[`USIM_C1_TXCAUSE];
  assign dlogic  = ctrl1_reg[`USIM_C1_DLOGIC];
  assign err_out = ctrl1_reg[`USIM_C1_ERROUT];

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------
  // address and data may arrive in either order; both are held until the response
  assign S_AXI_AWREADY_OUT = ~aw_hold & ~S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = ~w_hold & ~S_AXI_BVALID_OUT;
  assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;
  assign wr_go   = aw_hold & w_hold & ~S_AXI_BVALID_OUT;
  assign wr_hit  = (aw_addr <= `USIM_OFS_STAT) && (aw_addr[1:0] == 2'h0);
  assign wr_en   = wr_go & wr_hit & w_strb0;
  assign rd_go   = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  assign rd_hit  = (S_AXI_ARADDR_IN <= `USIM_OFS_STAT) && (S_AXI_ARADDR_IN[1:0] == 2'h0);

  // write channel capture and response
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      aw_hold          <= 1'b0;
      w_hold           <= 1'b0;
      aw_addr          <= 8'h00;
      w_data           <= 32'h0000_0000;
      w_strb0          <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= `USIM_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_hold  <= 1'b1;
        w_data  <= S_AXI_WDATA_IN;
        w_strb0 <= S_AXI_WSTRB_IN[0];
      end
      if (wr_go) begin
        aw_hold          <= 1'b0;
        w_hold           <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= wr_hit ? `USIM_RESP_OKAY : `USIM_RESP_SLVERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // read mux; masked control 1 bit 5 and unmapped words read zero, masked bits 1 and 3 read tx empty and rx full; control 0 bits read back as written
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR_IN)
      `USIM_OFS_MODE:  rd_word[7:0] = mode_reg;
      `USIM_OFS_CTRL0: rd_word[7:0] = ctrl0_reg;
      `USIM_OFS_CTRL1: begin
        rd_word[7:0] = ctrl1_reg;
        rd_word[`USIM_C1_TXEMPTY] = ~tx_full;
        rd_word[`USIM_C1_RXFULL]  = rx_full;
      end
      `USIM_OFS_BRG:   rd_word[7:0] = brg_m;
      `USIM_OFS_RXBUF: begin
        rd_word[7:0] = rx_buf ^ {8{dlogic}};
        rd_word[`USIM_RX_OVR] = ovr_err;
        rd_word[`USIM_RX_FRM] = frm_err;
        rd_word[`USIM_RX_PAR] = par_err;
        rd_word[`USIM_RX_SUM] = ovr_err | frm_err | par_err;
      end
      `USIM_OFS_STAT:  rd_word[3:0] = flags;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h0000_0000;
      S_AXI_RRESP_OUT  <= `USIM_RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT  <= rd_word;
      S_AXI_RRESP_OUT  <= rd_hit ? `USIM_RESP_OKAY : `USIM_RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  // reset leaves polarity reversal cleared
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      mode_reg  <= `USIM_RST_MODE;
      ctrl0_reg <= `USIM_RST_CTRL0;
      ctrl1_reg <= `USIM_RST_CTRL1;
      brg_m     <= `USIM_RST_BRG;
    end else if (wr_en) begin
      if (aw_addr == `USIM_OFS_MODE)  mode_reg  <= w_data[7:0];
      if (aw_addr == `USIM_OFS_CTRL0) ctrl0_reg <= w_data[7:0];
      if (aw_addr == `USIM_OFS_CTRL1) ctrl1_reg <= w_data[7:0] & `USIM_C1_WMASK;
      if (aw_addr == `USIM_OFS_BRG)   brg_m     <= w_data[7:0];
    end
  end

  // ------------------------------------------------------------------
  // bit rate and transmitter
  // ------------------------------------------------------------------
  usim_brg u_brg (
    .clk_in     (SYS_CLK_IN),
    .rst_n_in   (RESETN_IN),
    .ext_sel_in (mode_reg[`USIM_MODE_CKSEL]),
    .pre_sel_in (ctrl0_reg[1:0]),
    .m_in       (brg_m),
    .ext_clk_in (SERIAL_CLOCK_PIN_IN),
    .tick16_out (tick16)
  );

  // the cts gate is bypassed when flow control is disabled
  // start needs enable and a loaded buffer
  assign tx_load = tick16 & chan_on & txen & tx_full & ~tx_busy & (flowdis | ~CTS_N_IN);
  // bit order swap for msb first
  assign tx_data = msbf ? usim_rev8(tx_buf) : tx_buf;
  // parity sense from the even bit
  assign tx_par  = ^tx_buf ^ ~peven;
  assign frame   = pen ? {2'b11, tx_par, tx_data, 1'b0} : {3'b111, tx_data, 1'b0};
  // one stop bit unless the stop length bit is set
  assign nbits   = 4'hA + {3'h0, pen} + {3'h0, stop2};
  assign tx_done = tx_busy & tick16 & (tx_sub == `USIM_SUB_LAST) & (tx_left == 4'h1);

  // buffer write with inversion; a write in the load cycle keeps the buffer full
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      tx_buf  <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr_en && aw_addr == `USIM_OFS_TXBUF) begin
      tx_buf  <= w_data[7:0] ^ {8{dlogic}};
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  // shift register: sixteen ticks per bit
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      tx_busy  <= 1'b0;
      tx_shift <= 12'hFFF;
      tx_sub   <= 4'h0;
      tx_left  <= 4'h0;
    end else if (tx_load) begin
      tx_busy  <= 1'b1;
      tx_shift <= frame;
      tx_sub   <= 4'h0;
      tx_left  <= nbits;
    end else if (tx_busy && tick16) begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == `USIM_SUB_LAST) begin
        tx_shift <= {1'b1, tx_shift[11:1]};
        tx_left  <= tx_left - 4'h1;
        if (tx_left == 4'h1) tx_busy <= 1'b0;
      end
    end
  end

  // reversal wraps every line bit; error signal forces low
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      pin_q   <= 1'b1;
      err_drv <= 1'b0;
    end else begin
      pin_q   <= (err_cnt != 5'h00) ? 1'b0 : ((tx_busy ? tx_shift[0] : 1'b1) ^ rev);
      err_drv <= (err_cnt != 5'h00); // lines up with the forced low on the pin
    end
  end
  assign SERIAL_OUT_PIN_OUT = pin_q;
  // open drain only drives while low
  assign SERIAL_OUT_PIN_OE_OUT = odrain ? ~pin_q : 1'b1;

  // ------------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------------
  // input reversal
  assign rx_in   = SERIAL_IN_PIN_IN ^ rev;
  assign rx_raw  = pen ? rx_sh[7:0] : rx_sh[8:1];
  assign rx_pbit = rx_sh[8];
  assign pbad    = pen & (^rx_raw ^ rx_pbit ^ ~peven);
  assign rx_done = (rx_state == RX_STOP) & tick16 & (rx_sub == `USIM_SUB_LAST);

  // start is checked at mid bit, later bits every sixteen ticks from there
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      rx_state <= RX_IDLE;
      rx_sub   <= 4'h0;
      rx_cnt   <= 4'h0;
      rx_sh    <= 9'h000;
    end else if (!chan_on || !rxen) begin
      rx_state <= RX_IDLE;
    end else if (tick16) begin
      rx_sub <= rx_sub + 4'h1;
      unique case (rx_state)
        RX_IDLE: begin
          // start bit opens a frame
          // our own error low on the shared line must not look like a start bit
          if (!rx_in && !err_drv) begin
            rx_state <= RX_START;
            rx_sub   <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_sub == `USIM_SUB_MID) begin
            rx_state <= rx_in ? RX_IDLE : RX_BITS;
            rx_sub   <= 4'h0;
            rx_cnt   <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_sub == `USIM_SUB_LAST) begin
            rx_sh  <= {rx_in, rx_sh[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == 4'h7 + {3'h0, pen}) rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sub == `USIM_SUB_LAST) rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // error capture; a read in the completion cycle loses to the new char
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
      ovr_err <= 1'b0;
      frm_err <= 1'b0;
      par_err <= 1'b0;
    end else if (rx_done) begin
      rx_buf  <= msbf ? usim_rev8(rx_raw) : rx_raw;
      rx_full <= 1'b1;
      ovr_err <= rx_full;
      frm_err <= ~rx_in;
      par_err <= pbad;
    end else if (rd_go && S_AXI_ARADDR_IN == `USIM_OFS_RXBUF) begin
      rx_full <= 1'b0;
    end
  end

  // hold the line low for one bit time after a bad parity
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      err_cnt <= 5'h00;
    end else if (rx_done && pbad && err_out) begin
      err_cnt <= `USIM_ERR_TICKS;
    end else if (tick16 && err_cnt != 5'h00) begin
      err_cnt <= err_cnt - 5'h01;
    end
  end

  // ------------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------------
  // compare at mid bit, where the shared line has settled
  assign bc_ev = tx_busy & tick16 & (tx_sub == `USIM_SUB_MID) & (pin_q != SERIAL_IN_PIN_IN);
  // cause select; error output turns completion into error detection
  assign tx_ev = txcause ? (tx_done & (~err_out | ~SERIAL_IN_PIN_IN)) : tx_load;
  // far end error is the line level at completion
  assign ev_vec  = {tx_done & ~SERIAL_IN_PIN_IN, bc_ev, rx_done, tx_ev};
  assign clr_vec = (wr_en && aw_addr == `USIM_OFS_STAT) ? w_data[3:0] : 4'h0;

  // write one to clear; a new event wins over the clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      flags <= 4'h0;
    end else begin
      flags <= ev_vec | (flags & ~clr_vec);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  property p_tx_inv;
    (wr_en && aw_addr == `USIM_OFS_TXBUF) |=> (tx_buf == ($past(w_data[7:0]) ^ {8{$past(dlogic)}}));
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("tx buffer inversion wrong");
  property p_rev_idle;
    (!tx_busy && err_cnt == 5'h00) |=> (pin_q == !$past(rev));
  endproperty
  a_rev_idle: assert property (p_rev_idle) else $error("idle level ignores reversal");
  property p_bcol;
    bc_ev |=> flags[`USIM_ST_BCOL];
  endproperty
  a_bcol: assert property (p_bcol) else $error("collision not flagged");
  property p_bc_sticky;
    (flags[`USIM_ST_BCOL] && !clr_vec[`USIM_ST_BCOL]) |=> flags[`USIM_ST_BCOL];
  endproperty
  a_bc_sticky: assert property (p_bc_sticky) else $error("collision flag lost");
  property p_tx_start;
    $rose(tx_busy) |-> $past(txen && tx_full && chan_on);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit started unloaded");
  property p_start_bit;
    ($rose(tx_busy) && err_cnt == 5'h00) |=> (pin_q == rev);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit level wrong");
  property p_rx_start;
    (rx_state == RX_IDLE ##1 rx_state == RX_START) |-> $past(rxen);
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("receive began disabled");
  property p_rx_irq;
    rx_done |=> (flags[`USIM_ST_RX] && rx_full);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");
  sequence s_bad_char;
    rx_done && pbad && err_out;
  endsequence
  sequence s_line_low;
    ##1 (!pin_q)[*8];
  endsequence
  property p_err_sig;
    s_bad_char |=> s_line_low;
  endproperty
  a_err_sig: assert property (p_err_sig) else $error("error signal not driven");
  property p_odrain;
    (odrain && $past(odrain && !tx_busy && err_cnt == 5'h00 && !rev))
      |-> !SERIAL_OUT_PIN_OE_OUT;
  endproperty
  a_odrain: assert property (p_odrain) else $error("open drain drives high");
  property p_far;
    (tx_done && !SERIAL_IN_PIN_IN) |=> flags[`USIM_ST_FAR];
  endproperty
  a_far: assert property (p_far) else $error("far error not sampled");
endmodule

/* hdl/usim_params.svh */
// register map, field positions, reset values and counts for the smart-card uart
`ifndef USIM_PARAMS_SVH
`define USIM_PARAMS_SVH
// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define USIM_OFS_MODE  8'h00
`define USIM_OFS_CTRL0 8'h04
`define USIM_OFS_CTRL1 8'h08
`define USIM_OFS_BRG   8'h0C
`define USIM_OFS_TXBUF 8'h10
`define USIM_OFS_RXBUF 8'h14
`define USIM_OFS_STAT  8'h18
// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define USIM_MODE_UART8  3'h5
`define USIM_MODE_CKSEL  3
`define USIM_MODE_STOP2  4
`define USIM_MODE_PEVEN  5
`define USIM_MODE_PEN    6
`define USIM_MODE_REV    7
`define USIM_C0_FLOWDIS  4
`define USIM_C0_ODRAIN   5
`define USIM_C0_MSBF     7
`define USIM_C1_TXEN     0
`define USIM_C1_TXEMPTY  1
`define USIM_C1_RXEN     2
`define USIM_C1_RXFULL   3
`define USIM_C1_TXCAUSE  4
`define USIM_C1_DLOGIC   6
`define USIM_C1_ERROUT   7
`define USIM_C1_WMASK    8'hD5
`define USIM_ST_TX       0
`define USIM_ST_RX       1
`define USIM_ST_BCOL     2
`define USIM_ST_FAR      3
`define USIM_RX_OVR      12
`define USIM_RX_FRM      13
`define USIM_RX_PAR      14
`define USIM_RX_SUM      15
// --------------------------------------------------------------------
// reset values and counts
// --------------------------------------------------------------------
`define USIM_RST_MODE    8'h00
`define USIM_RST_CTRL0   8'h00
`define USIM_RST_CTRL1   8'h00
`define USIM_RST_BRG     8'h00
`define USIM_PRE_F8      5'h07
`define USIM_PRE_F32     5'h1F
`define USIM_SUB_MID     4'h7
`define USIM_SUB_LAST    4'hF
`define USIM_ERR_TICKS   5'h10
`define USIM_RESP_OKAY   2'h0
`define USIM_RESP_SLVERR 2'h2
`endif

/* hdl/usim_pkg.sv */
// types shared by the smart-card uart modules
package usim_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} usim_rx_e;
  typedef logic [7:0] usim_byte_t;
  // bit order swap for msb-first transfer
  function automatic usim_byte_t usim_rev8(input usim_byte_t d);
    usim_byte_t r;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return r;
  endfunction
endpackage

/* hdl/usim_brg.sv */
// bit rate generator: source select, prescale and divide by m+1
`include "usim_params.svh"
module usim_brg
  import usim_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ext_sel_in,
  input  wire logic [1:0] pre_sel_in,
  input  wire usim_byte_t m_in,
  input  wire logic       ext_clk_in,
  output logic            tick16_out
);
  logic [4:0] pre;
  logic       ext_prev;
  usim_byte_t cnt;
  logic       int_tick;
  logic       src_tick;

  // free-running prescaler for the internal sources
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre      <= 5'h00;
      ext_prev <= 1'b0;
    end else begin
      pre      <= pre + 5'h01;
      ext_prev <= ext_clk_in;
    end
  end

  assign int_tick = (pre_sel_in == 2'h0) ? 1'b1 :
                    (pre_sel_in == 2'h1) ? (pre[2:0] == 3'(`USIM_PRE_F8)) : (pre == `USIM_PRE_F32);
  assign src_tick = ext_sel_in ? (ext_clk_in & ~ext_prev) : int_tick;

  // divide by m+1, m from 00 to FF; the frame logic divides by 16 more
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt        <= 8'h00;
      tick16_out <= 1'b0;
    end else begin
      tick16_out <= 1'b0;
      if (src_tick) begin
        if (cnt == 8'h00) begin
          cnt        <= m_in;
          tick16_out <= 1'b1;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule

/* verification/usim_card.sv */
// card model sitting on the shared pulled-up serial line
module usim_card (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial low_out = 1'b0;
  // --------------------------------------------------------------------
  // frame capture and send
  // --------------------------------------------------------------------
  // capture eight bits in line order then parity, optionally signal bad parity
  task automatic take(input logic nack, output logic [8:0] got);
    while (line_in !== 1'b0) @(posedge clk_in);
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk_in);
      got[i] = line_in;
    end
    repeat (12) @(posedge clk_in);
    low_out <= nack;
    repeat (24) @(posedge clk_in);
    low_out <= 1'b0;
  endtask
  // the card can only pull low, release leaves the pull-up in charge
  task automatic give(input logic [8:0] bits, output logic lo);
    low_out <= 1'b1;
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      low_out <= ~bits[i];
      repeat (16) @(posedge clk_in);
    end
    low_out <= 1'b0;
    repeat (14) @(posedge clk_in);
    lo = line_in;
    repeat (30) @(posedge clk_in);
  endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the smart-card uart channel
`include "usim_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin, oe, card_low;
  logic [1:0]  bresp, rresp, wresp;
  logic [31:0] rdata;
  int          n_mismatch = 0;
  int          tests_run = 0;
  // out and in tied, pulled up
  wire line = (oe ? pin : 1'b1) & ~card_low;
  always #25 clk = ~clk;
  usim_card card (.clk_in(clk), .line_in(line), .low_out(card_low));
  // responses are always accepted, so ready lines stay high
  usim_top uut (
    .SYS_CLK_IN(clk), .RESETN_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(1'b1),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(1'b1), .SERIAL_IN_PIN_IN(line), .SERIAL_CLOCK_PIN_IN(1'b0),
    .CTS_N_IN(1'b1), .SERIAL_OUT_PIN_OUT(pin), .SERIAL_OUT_PIN_OE_OUT(oe));
  // --------------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // entered just after a rising edge; each channel is released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wresp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] c0, input logic [7:0] c1);
    wr(`USIM_OFS_CTRL0, {24'h0, c0});
    wr(`USIM_OFS_CTRL1, {24'h0, c1});
    wr(`USIM_OFS_MODE, {24'h0, m});
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic s_tx(input logic [7:0] m, c0, c1, d, input logic nack,
                      input logic [8:0] ebits, input logic [31:0] est);
    logic [8:0]  got;
    logic [31:0] v;
    logic [1:0]  r;
    cfg(m, c0, c1);
    wr(`USIM_OFS_TXBUF, {24'h0, d});
    card.take(nack, got);
    chk("frame", {23'h0, got}, {23'h0, ebits});
    rd(`USIM_OFS_STAT, v, r);
    chk("stat_tx", v, est);
    wr(`USIM_OFS_STAT, 32'hF);
    rd(`USIM_OFS_STAT, v, r);
    chk("stat_clear", v, 32'h0);
  endtask
  task automatic s_rx(input logic [7:0] c1, input logic [8:0] bits,
                      input logic [31:0] elo, input logic [31:0] erx);
    logic        lo;
    logic [31:0] v;
    logic [1:0]  r;
    cfg(8'h65, 8'h30, c1);
    card.give(bits, lo);
    chk("err_low", {31'h0, lo}, elo);
    rd(`USIM_OFS_RXBUF, v, r);
    chk("rxbuf", v, erx);
    rd(`USIM_OFS_STAT, v, r);
    chk("stat_rx", v, 32'h2);
    wr(`USIM_OFS_STAT, 32'hF);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`USIM_OFS_MODE, v, r);
    chk("mode_reset", v, 32'h0);
    wr(`USIM_OFS_BRG, 32'hFF);
    chk("bresp_ok", {30'h0, wresp}, {30'h0, `USIM_RESP_OKAY});
    rd(`USIM_OFS_BRG, v, r);
    chk("brg", v, 32'hFF);
    wr(`USIM_OFS_BRG, 32'h0);
    rd(8'h1C, v, r);
    chk("unmapped", {30'h0, r}, {30'h0, `USIM_RESP_SLVERR});
    wr(8'h1C, 32'h0);
    chk("unmapped_w", {30'h0, wresp}, {30'h0, `USIM_RESP_SLVERR});
    s_tx(8'h65, 8'h30, 8'h01, 8'hA5, 1'b0, 9'h0A5, 32'h1);
    s_tx(8'h45, 8'hB0, 8'h51, 8'h3B, 1'b0, 9'h023, 32'h1);
    s_tx(8'h65, 8'h30, 8'h91, 8'hA5, 1'b1, 9'h0A5, 32'hD);
    s_tx(8'h65, 8'h30, 8'h91, 8'h0F, 1'b0, 9'h00F, 32'h0);
    s_rx(8'h84, 9'h1A5, 32'h0, 32'hC0A5);
    s_rx(8'hC4, 9'h0A5, 32'h1, 32'h5A);
    cfg(8'hE5, 8'h10, 8'h00);
    repeat (2) @(posedge clk);
    chk("rev_idle", {31'h0, pin}, 32'h0);
    chk("push_pull_oe", {31'h0, oe}, 32'h1);
    stop_test();
  end
  // watchdog against a hung handshake or frame
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
